// file: design/flash_seq_pkg.sv
// Constants and types shared by the flash resume and OTP sequencer
package flash_seq_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int OTP_PROGRAM_TIME_US = 1000;
   localparam int OTP_PROGRAM_CYCLES = OTP_PROGRAM_TIME_US * (SYS_CLK_HZ / 1_000_000);
   localparam int TIMER_W = 24;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_OTP_READ = 8'h4B;
   localparam logic [7:0] CMD_OTP_PROGRAM = 8'h42;

   // ****************************************
   // Frame layout
   // ****************************************
   localparam logic [6:0] ONE_BYTE = 7'h01;
   localparam logic [6:0] HDR_BYTES = 7'h04;
   localparam logic [6:0] RD_DATA_START = 7'h05;
   localparam logic [6:0] BYTE_CNT_MAX = 7'h7F;

   // ****************************************
   // OTP area
   // ****************************************
   localparam int OTP_BYTES = 65;
   localparam logic [6:0] OTP_LAST_ADDR = 7'h40;
   localparam logic [6:0] OTP_MAX_DATA = 7'h41;
   localparam logic [7:0] OTP_ERASED = 8'hFF;
   localparam int LOCK_BIT = 0;
   localparam int LOCK_POS = 64 * 8 + LOCK_BIT;

   // ****************************************
   // Main array geometry
   // ****************************************
   localparam int ADDR_W = 26;
   localparam int PAGE_LSB = 8;
   localparam int SECTOR_LSB = 16;

   // ****************************************
   // Flag status register
   // ****************************************
   localparam logic [7:0] FSR_RESET = 8'h80;
   localparam int FSR_READY = 7;
   localparam int FSR_ERASE_SUSP = 6;
   localparam int FSR_PROG_FAIL = 4;
   localparam int FSR_PROG_SUSP = 2;
   localparam int FSR_PROTECT = 1;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_OTP_WRITE, SEQ_OTP_WAIT} seq_state_t;

endpackage

// file: design/flash_resume_and_otp_sequencer.sv
// Resume, suspend bookkeeping and OTP read/program sequencer of a serial flash
//
// Function
// - Resume is code 7Ah framed by chip select
// - Resume sets write-in-progress, clears ready flag
// - Resume ignored when nothing is suspended
// - Ready flag returns to one at completion
// - Program suspended: suspended page reads indeterminate
// - Erase suspended: other sectors stay usable
// - Program to suspended sector fails, bit 4
// - Erase resume skips lock re-evaluation
// - OTP read: rising sample, falling-edge output
// - OTP read address increments, sticks at 0x40
// - Chip select high stops output driving
// - OTP program needs write enable latch
// - OTP program starts on chip select rise
// - Keep at most 65 data bytes
// - Program 64 bytes plus control byte, busy
// - OTP end clears enable latch and busy
// - Timer end clears latch; fault sets program fail
// - Misaligned chip select: no program, no flags
// - Control byte bit 0 one means unlocked
// - Locked OTP: ignore, keep latch, bits 1,4
// - Suspends set flag bits 2 and 6
// - One program nested in erase, LIFO resume
`timescale 1ns/100ps
module flash_resume_and_otp_sequencer #(
   parameter int OTP_PROGRAM_CYCLES = flash_seq_pkg::OTP_PROGRAM_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic spi_clk_i,
   input wire logic cs_n_i,
   input wire logic host_to_flash_line_i,
   output logic flash_to_host_line_o,
   output logic flash_to_host_line_oe_n_o,
   input wire logic eng_busy_i,
   input wire logic eng_erase_i,
   input wire logic [flash_seq_pkg::ADDR_W-1:0] eng_addr_i,
   input wire logic eng_done_i,
   output logic eng_suspend_o,
   output logic eng_resume_o,
   output logic eng_resume_erase_o,
   input wire logic prog_req_i,
   input wire logic [flash_seq_pkg::ADDR_W-1:0] prog_addr_i,
   output logic prog_grant_o,
   output logic prog_reject_o,
   input wire logic [flash_seq_pkg::ADDR_W-1:0] read_addr_i,
   output logic read_indeterminate_o,
   input wire logic otp_fault_i,
   output logic otp_locked_o,
   output logic wip_o,
   output logic wel_o,
   output logic [7:0] flag_status_o
);

   // ****************************************
   // State types
   // ****************************************
   typedef struct packed {
      logic frame_tog;
      logic [2:0] bit_cnt;
      logic [6:0] byte_cnt;
      logic [7:0] shreg;
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [6:0] data_cnt;
      logic [6:0] rd_ptr;
      logic [flash_seq_pkg::OTP_BYTES*8-1:0] stage;
   } link_state_t;

   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      logic cs_prev;
      logic tog_meta;
      logic tog_sync;
      logic tog_seen;
      flash_seq_pkg::seq_state_t state;
      logic wel;
      logic wip;
      logic [7:0] fsr;
      logic susp_prog;
      logic susp_erase;
      logic [flash_seq_pkg::ADDR_W-1:0] susp_prog_addr;
      logic [flash_seq_pkg::ADDR_W-1:0] susp_erase_addr;
      logic resumed;
      logic [flash_seq_pkg::OTP_BYTES*8-1:0] otp;
      logic [6:0] wr_idx;
      logic [6:0] wr_addr;
      logic [6:0] wr_cnt;
      logic [flash_seq_pkg::TIMER_W-1:0] timer;
      logic fault;
      logic eng_suspend;
      logic eng_resume;
      logic eng_resume_erase;
      logic prog_grant;
      logic prog_reject;
      logic read_bad;
   } sys_state_t;

   localparam logic [flash_seq_pkg::TIMER_W-1:0] TIMER_LAST =
      flash_seq_pkg::TIMER_W'(OTP_PROGRAM_CYCLES - 1);

   function automatic logic same_region(input logic [flash_seq_pkg::ADDR_W-1:0] a,
                                        input logic [flash_seq_pkg::ADDR_W-1:0] b,
                                        input logic whole_sector);
      logic [flash_seq_pkg::ADDR_W-1:0] diff;
      diff = a ^ b;
      if (whole_sector) begin
         same_region = (diff >> flash_seq_pkg::SECTOR_LSB) == '0;
      end else begin
         same_region = (diff >> flash_seq_pkg::PAGE_LSB) == '0;
      end
   endfunction

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rst_pipe_reg;
   logic rst_n;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_pipe_reg <= 2'h0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe_reg[1];

   // ****************************************
   // Link domain: shifting in on rising edges
   // ****************************************
   link_state_t lk_reg;
   link_state_t lk_next;
   logic fresh_reg;
   logic dout_reg;
   logic [7:0] shv;
   logic [23:0] new_addr;
   logic reading;

   // Frame start marker, preset while chip select is high
   always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   assign shv = {lk_reg.shreg[6:0], host_to_flash_line_i};
   assign new_addr = {lk_reg.addr[15:0], shv};

   always_comb begin
      lk_next = lk_reg;
      if (fresh_reg) begin
         lk_next.bit_cnt = 3'h0;
         lk_next.byte_cnt = 7'h00;
         lk_next.data_cnt = 7'h00;
         lk_next.frame_tog = ~lk_reg.frame_tog;
      end
      lk_next.shreg = shv;
      lk_next.bit_cnt = lk_next.bit_cnt + 3'h1;
      if (lk_next.bit_cnt == 3'h0) begin
         if (lk_next.byte_cnt != flash_seq_pkg::BYTE_CNT_MAX) begin
            lk_next.byte_cnt = lk_next.byte_cnt + 7'h01;
         end
         if (lk_reg.byte_cnt == 7'h00 || fresh_reg) begin
            lk_next.cmd = shv;
         end else if (lk_reg.byte_cnt < flash_seq_pkg::HDR_BYTES) begin
            lk_next.addr = new_addr;
            if (new_addr > {17'h00000, flash_seq_pkg::OTP_LAST_ADDR}) begin
               lk_next.rd_ptr = flash_seq_pkg::OTP_LAST_ADDR;
            end else begin
               lk_next.rd_ptr = new_addr[6:0];
            end
         end else if (lk_reg.cmd == flash_seq_pkg::CMD_OTP_PROGRAM) begin
            if (lk_reg.data_cnt < flash_seq_pkg::OTP_MAX_DATA) begin
               lk_next.stage[{lk_reg.data_cnt, 3'h0} +: 8] = shv;
               lk_next.data_cnt = lk_reg.data_cnt + 7'h01;
            end
         end else if (lk_reg.cmd == flash_seq_pkg::CMD_OTP_READ &&
                      lk_reg.byte_cnt >= flash_seq_pkg::RD_DATA_START) begin
            if (lk_reg.rd_ptr != flash_seq_pkg::OTP_LAST_ADDR) begin
               lk_next.rd_ptr = lk_reg.rd_ptr + 7'h01;
            end
         end
      end
   end

   always_ff @(posedge spi_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lk_reg <= '0;
      end else begin
         lk_reg <= lk_next;
      end
   end

   // ****************************************
   // Link domain: output on falling edges
   // ****************************************
   logic [7:0] sys_otp_byte;
   sys_state_t s_reg;
   sys_state_t s_next;

   assign sys_otp_byte = s_reg.otp[{lk_reg.rd_ptr, 3'h0} +: 8];

   // data shifted out on falling edge
   always_ff @(negedge spi_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dout_reg <= 1'b0;
      end else begin
         dout_reg <= sys_otp_byte[~lk_reg.bit_cnt];
      end
   end

   assign reading = (lk_reg.cmd == flash_seq_pkg::CMD_OTP_READ) &&
                    (lk_reg.byte_cnt >= flash_seq_pkg::RD_DATA_START) && !fresh_reg;

   // chip select high releases the line
   assign flash_to_host_line_oe_n_o = cs_n_i | ~reading;
   assign flash_to_host_line_o = dout_reg;

   // ****************************************
   // System domain: command execution
   // ****************************************
   logic frame_end;
   logic one_byte;
   logic otp_frame_ok;

   assign frame_end = s_reg.cs_sync & ~s_reg.cs_prev & (s_reg.tog_sync != s_reg.tog_seen);
   assign one_byte = (lk_reg.byte_cnt == flash_seq_pkg::ONE_BYTE) && (lk_reg.bit_cnt == 3'h0);
   assign otp_frame_ok = (lk_reg.byte_cnt > flash_seq_pkg::HDR_BYTES) &&
                         (lk_reg.bit_cnt == 3'h0);

   always_comb begin
      s_next = s_reg;
      s_next.cs_meta = cs_n_i;
      s_next.cs_sync = s_reg.cs_meta;
      s_next.cs_prev = s_reg.cs_sync;
      s_next.tog_meta = lk_reg.frame_tog;
      s_next.tog_sync = s_reg.tog_meta;
      s_next.eng_suspend = 1'b0;
      s_next.eng_resume = 1'b0;
      s_next.prog_grant = 1'b0;
      s_next.prog_reject = 1'b0;
      // only the suspended program page or suspended erase sector is fenced
      s_next.read_bad =
         (s_reg.susp_prog & same_region(read_addr_i, s_reg.susp_prog_addr, 1'b0)) |
         (s_reg.susp_erase & same_region(read_addr_i, s_reg.susp_erase_addr, 1'b1));
      if (s_reg.state != flash_seq_pkg::SEQ_IDLE && otp_fault_i) begin
         s_next.fault = 1'b1;
      end
      if (prog_req_i) begin
         if (s_reg.susp_erase && same_region(prog_addr_i, s_reg.susp_erase_addr, 1'b1)) begin
            s_next.fsr[flash_seq_pkg::FSR_PROG_FAIL] = 1'b1;
            s_next.prog_reject = 1'b1;
         end else begin
            s_next.prog_grant = 1'b1;
         end
      end
      if (eng_done_i && s_reg.resumed) begin
         s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b1;
         s_next.wip = 1'b0;
         s_next.resumed = 1'b0;
      end
      if (frame_end) begin
         s_next.tog_seen = s_reg.tog_sync;
         case (lk_reg.cmd)
            flash_seq_pkg::CMD_WRITE_ENABLE: begin
               if (one_byte) begin
                  s_next.wel = 1'b1;
               end
            end
            flash_seq_pkg::CMD_SUSPEND: begin
               // suspend flags, program nests in erase
               if (one_byte && eng_busy_i && !eng_erase_i && !s_reg.susp_prog) begin
                  s_next.susp_prog = 1'b1;
                  s_next.susp_prog_addr = eng_addr_i;
                  s_next.fsr[flash_seq_pkg::FSR_PROG_SUSP] = 1'b1;
                  s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b1;
                  s_next.eng_suspend = 1'b1;
                  s_next.wip = 1'b0;
                  s_next.resumed = 1'b0;
               end else if (one_byte && eng_busy_i && eng_erase_i && !s_reg.susp_erase &&
                            !s_reg.susp_prog) begin
                  s_next.susp_erase = 1'b1;
                  s_next.susp_erase_addr = eng_addr_i;
                  s_next.fsr[flash_seq_pkg::FSR_ERASE_SUSP] = 1'b1;
                  s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b1;
                  s_next.eng_suspend = 1'b1;
                  s_next.wip = 1'b0;
                  s_next.resumed = 1'b0;
               end
            end
            flash_seq_pkg::CMD_RESUME: begin
               if (one_byte && s_reg.susp_prog) begin
                  s_next.susp_prog = 1'b0;
                  s_next.fsr[flash_seq_pkg::FSR_PROG_SUSP] = 1'b0;
                  s_next.eng_resume_erase = 1'b0;
               end else if (one_byte && s_reg.susp_erase) begin
                  s_next.susp_erase = 1'b0;
                  s_next.fsr[flash_seq_pkg::FSR_ERASE_SUSP] = 1'b0;
                  s_next.eng_resume_erase = 1'b1;
               end
               if (one_byte && (s_reg.susp_prog || s_reg.susp_erase)) begin
                  s_next.eng_resume = 1'b1;
                  s_next.wip = 1'b1;
                  s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b0;
                  s_next.resumed = 1'b1;
               end
            end
            flash_seq_pkg::CMD_OTP_PROGRAM: begin
               if (s_reg.wel && otp_frame_ok && s_reg.state == flash_seq_pkg::SEQ_IDLE &&
                   !s_reg.wip) begin
                  if (!s_reg.otp[flash_seq_pkg::LOCK_POS]) begin
                     // locked: flag bits 1 and 4
                     s_next.fsr[flash_seq_pkg::FSR_PROTECT] = 1'b1;
                     s_next.fsr[flash_seq_pkg::FSR_PROG_FAIL] = 1'b1;
                  end else begin
                     s_next.state = flash_seq_pkg::SEQ_OTP_WRITE;
                     s_next.wip = 1'b1;
                     s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b0;
                     s_next.fault = 1'b0;
                     s_next.wr_idx = 7'h00;
                     s_next.wr_cnt = lk_reg.data_cnt;
                     if (lk_reg.addr > {17'h00000, flash_seq_pkg::OTP_LAST_ADDR}) begin
                        s_next.wr_addr = flash_seq_pkg::OTP_MAX_DATA;
                     end else begin
                        s_next.wr_addr = lk_reg.addr[6:0];
                     end
                  end
               end
               // misaligned frame leaves all as is
            end
            default: begin
            end
         endcase
      end
      case (s_reg.state)
         flash_seq_pkg::SEQ_IDLE: begin
         end
         flash_seq_pkg::SEQ_OTP_WRITE: begin
            // at most 64 bytes plus control byte
            if (s_reg.wr_idx == s_reg.wr_cnt || s_reg.wr_addr > flash_seq_pkg::OTP_LAST_ADDR) begin
               s_next.state = flash_seq_pkg::SEQ_OTP_WAIT;
               s_next.timer = '0;
            end else begin
               s_next.otp[{s_reg.wr_addr, 3'h0} +: 8] = s_reg.otp[{s_reg.wr_addr, 3'h0} +: 8] &
                                                       lk_reg.stage[{s_reg.wr_idx, 3'h0} +: 8];
               s_next.wr_idx = s_reg.wr_idx + 7'h01;
               s_next.wr_addr = s_reg.wr_addr + 7'h01;
            end
         end
         flash_seq_pkg::SEQ_OTP_WAIT: begin
            s_next.timer = s_reg.timer + 1'b1;
            if (s_reg.timer == TIMER_LAST) begin
               // latch and busy cleared at end
               s_next.state = flash_seq_pkg::SEQ_IDLE;
               s_next.wip = 1'b0;
               s_next.wel = 1'b0;
               s_next.fsr[flash_seq_pkg::FSR_READY] = 1'b1;
               if (s_reg.fault || otp_fault_i) begin
                  s_next.fsr[flash_seq_pkg::FSR_PROG_FAIL] = 1'b1;
               end
            end
         end
         default: begin
            s_next.state = flash_seq_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.cs_meta <= 1'b1;
         s_reg.cs_sync <= 1'b1;
         s_reg.cs_prev <= 1'b1;
         s_reg.fsr <= flash_seq_pkg::FSR_RESET;
         s_reg.otp <= {flash_seq_pkg::OTP_BYTES{flash_seq_pkg::OTP_ERASED}};
         s_reg.state <= flash_seq_pkg::SEQ_IDLE;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign eng_suspend_o = s_reg.eng_suspend;
   assign eng_resume_o = s_reg.eng_resume;
   assign eng_resume_erase_o = s_reg.eng_resume_erase;
   assign prog_grant_o = s_reg.prog_grant;
   assign prog_reject_o = s_reg.prog_reject;
   assign read_indeterminate_o = s_reg.read_bad;
   assign otp_locked_o = ~s_reg.otp[flash_seq_pkg::LOCK_POS];
   assign wip_o = s_reg.wip;
   assign wel_o = s_reg.wel;
   assign flag_status_o = s_reg.fsr;

endmodule

// file: test/flash_seq_chk.sv
// Port assertions for the resume and OTP sequencer
`timescale 1ns/100ps
module flash_seq_chk #(
   parameter int OTP_PROGRAM_CYCLES = 8
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic flash_to_host_line_oe_n_o,
   input wire logic eng_done_i,
   input wire logic eng_suspend_o,
   input wire logic eng_resume_o,
   input wire logic prog_req_i,
   input wire logic prog_grant_o,
   input wire logic prog_reject_o,
   input wire logic read_indeterminate_o,
   input wire logic otp_locked_o,
   input wire logic wip_o,
   input wire logic wel_o,
   input wire logic [7:0] flag_status_o
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_busy;
      wip_o && !flag_status_o[7];
   endsequence
   sequence s_susp;
      flag_status_o[2] || flag_status_o[6];
   endsequence
   a_oe_cs_high: assert property (cs_n_i |-> flash_to_host_line_oe_n_o)
      else $error("output enabled while deselected");
   a_grant_cause: assert property (prog_grant_o |-> $past(prog_req_i) && !prog_reject_o)
      else $error("grant without request");
   a_reject_flag: assert property (prog_reject_o |-> flag_status_o[4] && $stable(wel_o))
      else $error("reject without fail flag");
   a_resume_cause: assert property ($rose(eng_resume_o) |->
      $past(flag_status_o[2] || flag_status_o[6]))
      else $error("resume with nothing suspended");
   a_resume_busy: assert property ($rose(eng_resume_o) |-> ##[0:1] s_busy)
      else $error("resume not busy");
   a_done_ready: assert property (eng_done_i && ce_i && wip_o |=> flag_status_o[7] && !wip_o)
      else $error("ready not back after done");
   a_lock_sticky: assert property (otp_locked_o |=> otp_locked_o)
      else $error("lock released");
   a_wip_ready: assert property (wip_o |-> !flag_status_o[7])
      else $error("busy while ready");
   a_otp_end_wel: assert property ($fell(wip_o) && !$past(eng_done_i) |-> !wel_o)
      else $error("latch kept after program");
   a_susp_flag: assert property ($rose(eng_suspend_o) |-> ##[0:2] s_susp)
      else $error("suspend flag missing");
   a_indet_cause: assert property (read_indeterminate_o |->
      $past(flag_status_o[2] || flag_status_o[6]))
      else $error("indeterminate with nothing suspended");
endmodule
bind flash_resume_and_otp_sequencer flash_seq_chk #(
   .OTP_PROGRAM_CYCLES(OTP_PROGRAM_CYCLES)
) chk_u (.sys_clk_i, .rstn_i, .ce_i, .cs_n_i, .flash_to_host_line_oe_n_o, .eng_done_i,
   .eng_suspend_o, .eng_resume_o, .prog_req_i, .prog_grant_o, .prog_reject_o,
   .read_indeterminate_o, .otp_locked_o, .wip_o, .wel_o, .flag_status_o);

// file: test/spi_host_model.sv
// Serial host model driving framed transfers on the link
`timescale 1ns/100ps
module spi_host_model (
   output logic spi_clk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic oe_n_i
);
   initial begin
      spi_clk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx[$], input int xb, input int nrd,
      output logic [7:0] rx[$], output logic oe_bad);
      logic [7:0] b;
      rx = {};
      oe_bad = 1'b0;
      #1 cs_n_o = 1'b0;
      #6;
      // MSB first, set before rising edge
      for (int i = 0; i < tx.size() * 8 + xb; i++) begin
         mosi_o = (i < tx.size() * 8) ? tx[i / 8][7 - i % 8] : ~mosi_o;
         #6 spi_clk_o = 1'b1;
         #6 spi_clk_o = 1'b0;
      end
      for (int j = 0; j < nrd * 8; j++) begin
         mosi_o = ~mosi_o;
         #6 spi_clk_o = 1'b1;
         b = {b[6:0], miso_i};
         oe_bad = oe_bad | oe_n_i;
         #6 spi_clk_o = 1'b0;
         if (j % 8 == 7) rx.push_back(b);
      end
      // select rises xb bits past a byte boundary
      #6 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #500;
   endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the resume and OTP sequencer
`timescale 1ns/100ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic eng_busy_i = 1'b0, eng_erase_i = 1'b0, eng_done_i = 1'b0;
   logic prog_req_i = 1'b0, otp_fault_i = 1'b0;
   logic [flash_seq_pkg::ADDR_W-1:0] eng_addr_i = '0, prog_addr_i = '0, read_addr_i = '0, s_a;
   wire spi_clk, cs_n, mosi, miso, oe_n, susp, res, res_e, grant, reject, indet, locked, wip, wel;
   wire [7:0] fsr;
   logic [7:0] otp_m[65], e_fsr, rx[$], d[$];
   logic e_wel, e_wip, oe_bad, res_erase;
   int n_mismatch = 0, compares = 0, n_res = 0, n_susp = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   flash_resume_and_otp_sequencer #(.OTP_PROGRAM_CYCLES(8)) dut_u (.sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i), .ce_i(1'b1), .spi_clk_i(spi_clk), .cs_n_i(cs_n),
      .host_to_flash_line_i(mosi), .flash_to_host_line_o(miso),
      .flash_to_host_line_oe_n_o(oe_n), .eng_busy_i(eng_busy_i), .eng_erase_i(eng_erase_i),
      .eng_addr_i(eng_addr_i), .eng_done_i(eng_done_i), .eng_suspend_o(susp),
      .eng_resume_o(res), .eng_resume_erase_o(res_e), .prog_req_i(prog_req_i),
      .prog_addr_i(prog_addr_i), .prog_grant_o(grant), .prog_reject_o(reject),
      .read_addr_i(read_addr_i), .read_indeterminate_o(indet), .otp_fault_i(otp_fault_i),
      .otp_locked_o(locked), .wip_o(wip), .wel_o(wel), .flag_status_o(fsr));
   spi_host_model hm_u (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
      .oe_n_i(oe_n));
   always @(posedge sys_clk_i) begin
      if (susp === 1'b1) n_susp++;
      if (res === 1'b1) begin
         n_res++;
         res_erase = res_e;
      end
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic chk_st(input string msg);
      chk(wip, e_wip, msg);
      chk(wel, e_wel, msg);
      chk(fsr, e_fsr, msg);
      chk(oe_n, 1'b1, msg);
      chk(locked, !otp_m[64][0], msg);
      $display("step %s done", msg);
   endtask
   task automatic do_reset;
      rstn_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      foreach (otp_m[i]) otp_m[i] = 8'hFF;
      e_fsr = 8'h80;
      e_wel = 1'b0;
      e_wip = 1'b0;
      #1 chk_st("reset");
   endtask
   task automatic cmd(input logic [7:0] c);
      hm_u.xfer({c}, 0, 0, rx, oe_bad);
   endtask
   task automatic otp_prog(input int a, input logic [7:0] dq[$], input int xb);
      int i;
      hm_u.xfer({flash_seq_pkg::CMD_OTP_PROGRAM, 8'h00, 8'h00, 8'(a), dq}, xb, 0, rx, oe_bad);
      if (e_wel && xb == 0 && otp_m[64][0]) begin
         chk(wip, 8'h01, "otp busy");
         foreach (dq[k]) if (a + k <= 64) otp_m[a + k] &= dq[k];
         for (i = 0; i < 300 && wip !== 1'b0; i++) @(posedge sys_clk_i);
         if (i == 300) begin
            chk(wip, 8'h00, "wip stuck");
            report_and_stop();
         end
         #1 e_wel = 1'b0;
         if (otp_fault_i) e_fsr[4] = 1'b1;
      end else if (e_wel && xb == 0) e_fsr |= 8'h12;
      chk_st("otp program");
   endtask
   task automatic otp_read(input int a, input int n);
      hm_u.xfer({flash_seq_pkg::CMD_OTP_READ, 8'h00, 8'h00, 8'(a), 8'h00}, 0, n, rx, oe_bad);
      chk(oe_bad, 1'b0, "read enable");
      foreach (rx[i]) chk(rx[i], otp_m[(a + i > 64) ? 64 : a + i], "otp data");
      chk_st("otp read");
   endtask
   task automatic susp_op(input logic er, input logic [25:0] a);
      @(posedge sys_clk_i) eng_busy_i <= 1'b1;
      eng_erase_i <= er;
      eng_addr_i <= a;
      cmd(flash_seq_pkg::CMD_SUSPEND);
      @(posedge sys_clk_i) eng_busy_i <= 1'b0;
      e_fsr[er ? 6 : 2] = 1'b1;
      #1 chk_st("suspend");
   endtask
   task automatic req(input logic [25:0] a, input logic rej);
      @(posedge sys_clk_i) prog_req_i <= 1'b1;
      prog_addr_i <= a;
      @(posedge sys_clk_i) prog_req_i <= 1'b0;
      #1 chk(reject, rej, "reject");
      chk(grant, !rej, "grant");
   endtask
   task automatic rd(input logic [25:0] a, input logic ind);
      @(posedge sys_clk_i) read_addr_i <= a;
      @(posedge sys_clk_i) #1 chk(indet, ind, "indeterminate");
   endtask
   task automatic resume(input logic er);
      cmd(flash_seq_pkg::CMD_RESUME);
      e_fsr[er ? 6 : 2] = 1'b0;
      e_fsr[7] = 1'b0;
      e_wip = 1'b1;
      chk_st("resume");
      chk(res_erase, er, "resume kind");
      @(posedge sys_clk_i) eng_done_i <= 1'b1;
      @(posedge sys_clk_i) eng_done_i <= 1'b0;
      @(posedge sys_clk_i) e_fsr[7] = 1'b1;
      e_wip = 1'b0;
      #1 chk_st("resumed op done");
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(68));
      do_reset();
      otp_prog(0, {8'h5A}, 0);
      repeat (66) d.push_back(8'($urandom));
      d[64] = 8'hFF;
      cmd(flash_seq_pkg::CMD_WRITE_ENABLE);
      e_wel = 1'b1;
      otp_prog(0, d, 3);
      otp_prog(0, d, 0);
      otp_read(62, 5);
      otp_read(0, 3);
      cmd(flash_seq_pkg::CMD_WRITE_ENABLE);
      e_wel = 1'b1;
      otp_prog(64, {8'hFE}, 0);
      cmd(flash_seq_pkg::CMD_WRITE_ENABLE);
      e_wel = 1'b1;
      otp_prog(0, {8'h00}, 0);
      otp_read(0, 1);
      do_reset();
      cmd(flash_seq_pkg::CMD_RESUME);
      chk(n_res, 0, "resume idle");
      s_a = 26'($urandom_range(1, 500)) << 16;
      susp_op(1'b1, s_a);
      req(s_a + 26'h5, 1'b1);
      e_fsr[4] = 1'b1;
      req(s_a + 26'h10000, 1'b0);
      susp_op(1'b0, s_a + 26'h10020);
      rd(s_a + 26'h10021, 1'b1);
      rd(s_a + 26'h3, 1'b1);
      rd(s_a + 26'h20000, 1'b0);
      resume(1'b0);
      resume(1'b1);
      chk(n_res, 2, "resume count");
      chk(n_susp, 2, "suspend count");
      do_reset();
      cmd(flash_seq_pkg::CMD_WRITE_ENABLE);
      e_wel = 1'b1;
      otp_fault_i <= 1'b1;
      otp_prog(0, {8'h3C}, 0);
      report_and_stop();
   end
endmodule
